// ===== design/rodc_pkg.sv
package rodc_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_CRYSTAL_TUNING_CTRL = 8'h1b;
    localparam logic [7:0] ADDR_RESERVED_CRYSTAL    = 8'h1c;
    localparam logic [7:0] ADDR_REFERENCE_PATH_CTRL = 8'h1d;
    localparam logic [7:0] ADDR_PRIMARY_OUTPUT_DRV  = 8'h32;

    // Values after reset
    localparam logic [7:0] RST_CRYSTAL_TUNING_CTRL  = 8'h80;
    localparam logic [7:0] RST_REFERENCE_PATH_CTRL  = 8'h00;
    localparam logic [7:0] RST_PRIMARY_OUTPUT_DRV   = 8'ha8;

    // Writable bits; everything else is unused, reads zero
    localparam logic [7:0] MASK_CRYSTAL_TUNING_CTRL = 8'hbf;
    localparam logic [7:0] MASK_REFERENCE_PATH_CTRL = 8'h05;
    localparam logic [7:0] MASK_PRIMARY_OUTPUT_DRV  = 8'hff;

    // Crystal tuning control fields
    localparam int CRYS_AUTO_BIT  = 7;
    localparam int CRYS_CODE_MSB  = 5;
    localparam int CRYS_CODE_LSB  = 0;
    localparam int CRYS_CODE_W    = 6;

    // Reference path control fields
    localparam int REF_DOUBLER_BIT       = 2;
    localparam int REF_FORCE_CRYSTAL_BIT = 0;

    // Primary output driver control fields
    localparam int DRV_STRONG_BIT = 7;
    localparam int DRV_PDOWN_BIT  = 6;
    localparam int DRV_MODE_MSB   = 5;
    localparam int DRV_MODE_LSB   = 3;
    localparam int DRV_POL_MSB    = 2;
    localparam int DRV_POL_LSB    = 1;
    localparam int DRV_SER_EN_BIT = 0;

    // Pin indices of the differential pair
    localparam int PIN_POS   = 0;
    localparam int PIN_NEG   = 1;
    localparam int PIN_COUNT = 2;

    typedef enum logic [2:0] {
        RODC_MODE_CMOS_BOTH = 3'h0,
        RODC_MODE_CMOS_POS  = 3'h1,
        RODC_MODE_CMOS_NEG  = 3'h2,
        RODC_MODE_CMOS_NONE = 3'h3,
        RODC_MODE_LVDS      = 3'h4,
        RODC_MODE_LVPECL    = 3'h5,
        RODC_MODE_UNUSED6   = 3'h6,
        RODC_MODE_UNUSED7   = 3'h7
    } rodc_mode_e;

endpackage : rodc_pkg

// ===== design/rodc_drv_decode.sv
`timescale 1ns/10ps
`default_nettype none

module rodc_drv_decode (
    input  wire logic [7:0] drv_ctrl_in,         // Primary output driver register
    input  wire logic       std_select_in,       // Output standard select pin, 1 = LVPECL
    output logic            strong_out,          // Strong drive
    output logic            power_down_out,      // Driver powered down
    output logic [2:0]      mode_out,            // Effective mode code
    output logic            cmos_out,            // CMOS mode in force
    output logic            lvds_out,            // LVDS mode in force
    output logic            lvpecl_out,          // LVPECL mode in force
    output logic [1:0]      pin_en_out,          // Per pin drive enable {neg, pos}
    output logic [1:0]      pin_inv_out          // Per pin inversion {neg, pos}
);

    logic             ser_en;
    logic [1:0]       pol;
    rodc_pkg::rodc_mode_e mode;
    logic [1:0]       pin_en_raw;
    logic [1:0]       pin_inv_raw;

    always_comb begin
        ser_en = drv_ctrl_in[rodc_pkg::DRV_SER_EN_BIT];
        pol    = drv_ctrl_in[rodc_pkg::DRV_POL_MSB:rodc_pkg::DRV_POL_LSB];
        if (ser_en) begin
            mode           = rodc_pkg::rodc_mode_e'(drv_ctrl_in[rodc_pkg::DRV_MODE_MSB:rodc_pkg::DRV_MODE_LSB]);
            strong_out     = drv_ctrl_in[rodc_pkg::DRV_STRONG_BIT];
            power_down_out = drv_ctrl_in[rodc_pkg::DRV_PDOWN_BIT];
        end else begin
            // Pin strap picks the standard; drive settles to its reset setting
            mode           = std_select_in ? rodc_pkg::RODC_MODE_LVPECL : rodc_pkg::RODC_MODE_LVDS;
            strong_out     = 1'b1;
            power_down_out = 1'b0;
        end
        mode_out   = mode;
        cmos_out   = (mode[2] == 1'b0);
        lvds_out   = (mode == rodc_pkg::RODC_MODE_LVDS);
        lvpecl_out = (mode == rodc_pkg::RODC_MODE_LVPECL);
        // Unused codes 110/111 drive nothing, so a stray write cannot short a pair
        pin_en_raw[rodc_pkg::PIN_POS]  = ~mode[1];
        pin_en_raw[rodc_pkg::PIN_NEG]  = ~mode[0];
        pin_inv_raw[rodc_pkg::PIN_POS] = pol[1];
        pin_inv_raw[rodc_pkg::PIN_NEG] = ~pol[0];
    end

    // Single-ended pin controls only mean something in CMOS modes
    for (genvar i = 0; i < rodc_pkg::PIN_COUNT; i++) begin : g_pin
        assign pin_en_out[i]  = cmos_out & pin_en_raw[i];
        assign pin_inv_out[i] = cmos_out & pin_inv_raw[i];
    end

endmodule : rodc_drv_decode

`default_nettype wire

// ===== design/rodc_regs.sv
`timescale 1ns/10ps
`default_nettype none

module rodc_regs (
    input  wire logic       clk_in,                      // 250 MHz clock
    input  wire logic       arst_n_in,                   // Asynchronous reset, active low
    input  wire logic       reg_wr_en_in,                // Register write strobe from serial port
    input  wire logic       reg_rd_en_in,                // Register read strobe from serial port
    input  wire logic [7:0] reg_addr_in,                 // Register address
    input  wire logic [7:0] reg_wdata_in,                // Write data
    input  wire logic       ext_ref_detect_in,           // External reference signal present
    input  wire logic       output_standard_select_pin_in, // Strap pin, 1 = LVPECL, 0 = LVDS
    output logic [7:0]      reg_rdata_out,               // Read data
    output logic            reg_rvalid_out,              // Read data valid pulse
    output logic            crystal_cap_auto_out,        // Device picks tuning capacitance
    output logic [5:0]      crystal_cap_qtr_pf_out,      // Added capacitance in 0.25 pF units
    output logic            doubler_en_out,              // 2x multiplier in reference path
    output logic            use_ext_ref_out,             // External reference routed
    output logic            use_crystal_input_out,       // Crystal input routed
    output logic            drv_strong_out,              // Strong drive
    output logic            drv_power_down_out,          // Driver powered down
    output logic [2:0]      drv_mode_out,                // Effective driver mode code
    output logic            drv_cmos_out,                // CMOS mode active
    output logic            drv_lvds_out,                // LVDS mode active
    output logic            drv_lvpecl_out,              // LVPECL mode active
    output logic [1:0]      drv_pin_en_out,              // Per pin enable {neg, pos}
    output logic [1:0]      drv_pin_inv_out              // Per pin inversion {neg, pos}
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] crystal_tuning_ctrl;
    logic [7:0] reference_path_ctrl;
    logic [7:0] primary_output_driver_ctrl;
    logic [7:0] next_crystal_tuning_ctrl;
    logic [7:0] next_reference_path_ctrl;
    logic [7:0] next_primary_output_driver_ctrl;

    // Unused bits are masked on the way in, so the read path needs no mask of its own
    always_comb begin
        next_crystal_tuning_ctrl        = crystal_tuning_ctrl;
        next_reference_path_ctrl        = reference_path_ctrl;
        next_primary_output_driver_ctrl = primary_output_driver_ctrl;
        if (reg_wr_en_in) begin
            case (reg_addr_in)
                rodc_pkg::ADDR_CRYSTAL_TUNING_CTRL: begin
                    next_crystal_tuning_ctrl = reg_wdata_in & rodc_pkg::MASK_CRYSTAL_TUNING_CTRL;
                end
                rodc_pkg::ADDR_REFERENCE_PATH_CTRL: begin
                    next_reference_path_ctrl = reg_wdata_in & rodc_pkg::MASK_REFERENCE_PATH_CTRL;
                end
                rodc_pkg::ADDR_PRIMARY_OUTPUT_DRV: begin
                    // Every bit is live here; the mask only keeps the three writes alike
                    next_primary_output_driver_ctrl = reg_wdata_in & rodc_pkg::MASK_PRIMARY_OUTPUT_DRV;
                end
                default: begin
                    // Reserved 0x1c and unmapped addresses hold no state
                    next_crystal_tuning_ctrl = crystal_tuning_ctrl;
                end
            endcase
        end
    end

    // Reset leaves the crystal on automatic tuning and the driver under strap control
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crystal_tuning_ctrl        <= rodc_pkg::RST_CRYSTAL_TUNING_CTRL;
            reference_path_ctrl        <= rodc_pkg::RST_REFERENCE_PATH_CTRL;
            primary_output_driver_ctrl <= rodc_pkg::RST_PRIMARY_OUTPUT_DRV;
        end else begin
            crystal_tuning_ctrl        <= next_crystal_tuning_ctrl;
            reference_path_ctrl        <= next_reference_path_ctrl;
            primary_output_driver_ctrl <= next_primary_output_driver_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] next_reg_rdata;
    logic       next_reg_rvalid;

    // Read data holds between reads so a slow serial engine may fetch it late
    // A read and a write to one address in one cycle return the old value
    always_comb begin
        next_reg_rvalid = reg_rd_en_in;
        next_reg_rdata  = reg_rdata_out;
        if (reg_rd_en_in) begin
            case (reg_addr_in)
                rodc_pkg::ADDR_CRYSTAL_TUNING_CTRL: begin
                    next_reg_rdata = crystal_tuning_ctrl;
                end
                rodc_pkg::ADDR_REFERENCE_PATH_CTRL: begin
                    next_reg_rdata = reference_path_ctrl;
                end
                rodc_pkg::ADDR_PRIMARY_OUTPUT_DRV: begin
                    next_reg_rdata = primary_output_driver_ctrl;
                end
                default: begin
                    next_reg_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rdata_out  <= next_reg_rdata;
            reg_rvalid_out <= next_reg_rvalid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Crystal and reference path

    logic       next_cap_auto;
    logic [5:0] next_cap_qtr_pf;
    logic       next_doubler_en;
    logic       next_use_ext_ref;
    logic       force_crystal;
    logic [5:0] tune_code;

    // Detect is taken as synchronous; a detector in another domain needs a synchroniser upstream
    // Routing follows the detect input one edge late, like every other derived output
    always_comb begin
        next_cap_auto = crystal_tuning_ctrl[rodc_pkg::CRYS_AUTO_BIT];
        tune_code     = crystal_tuning_ctrl[rodc_pkg::CRYS_CODE_MSB:rodc_pkg::CRYS_CODE_LSB];
        // Inverted code: all ones adds nothing, all zeros adds 63 quarter pF
        next_cap_qtr_pf = next_cap_auto ? 6'h00 : ~tune_code;
        next_doubler_en = reference_path_ctrl[rodc_pkg::REF_DOUBLER_BIT];
        force_crystal   = reference_path_ctrl[rodc_pkg::REF_FORCE_CRYSTAL_BIT];
        // Detection is ignored entirely while the override is set
        next_use_ext_ref = ~force_crystal & ext_ref_detect_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            crystal_cap_auto_out   <= 1'b1;
            crystal_cap_qtr_pf_out <= 6'h00;
            doubler_en_out         <= 1'b0;
            use_ext_ref_out        <= 1'b0;
            use_crystal_input_out  <= 1'b1;
        end else begin
            crystal_cap_auto_out   <= next_cap_auto;
            crystal_cap_qtr_pf_out <= next_cap_qtr_pf;
            doubler_en_out         <= next_doubler_en;
            use_ext_ref_out        <= next_use_ext_ref;
            use_crystal_input_out  <= ~next_use_ext_ref;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Primary output driver

    logic       dec_strong;
    logic       dec_power_down;
    logic [2:0] dec_mode;
    logic       dec_cmos;
    logic       dec_lvds;
    logic       dec_lvpecl;
    logic [1:0] dec_pin_en;
    logic [1:0] dec_pin_inv;

    // Field meanings live in one place so a second driver could reuse them
    rodc_drv_decode u_drv_decode (
        .drv_ctrl_in    (primary_output_driver_ctrl),
        .std_select_in  (output_standard_select_pin_in),
        .strong_out     (dec_strong),
        .power_down_out (dec_power_down),
        .mode_out       (dec_mode),
        .cmos_out       (dec_cmos),
        .lvds_out       (dec_lvds),
        .lvpecl_out     (dec_lvpecl),
        .pin_en_out     (dec_pin_en),
        .pin_inv_out    (dec_pin_inv)
    );

    // Registered so the analog controls never see decode glitches
    // Reset shows the strap-low decode; the strap takes over at the first edge
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            drv_strong_out     <= 1'b1;
            drv_power_down_out <= 1'b0;
            drv_mode_out       <= 3'h4;
            drv_cmos_out       <= 1'b0;
            drv_lvds_out       <= 1'b1;
            drv_lvpecl_out     <= 1'b0;
            drv_pin_en_out     <= 2'h0;
            drv_pin_inv_out    <= 2'h0;
        end else begin
            drv_strong_out     <= dec_strong;
            drv_power_down_out <= dec_power_down;
            drv_mode_out       <= dec_mode;
            drv_cmos_out       <= dec_cmos;
            drv_lvds_out       <= dec_lvds;
            drv_lvpecl_out     <= dec_lvpecl;
            drv_pin_en_out     <= dec_pin_en;
            drv_pin_inv_out    <= dec_pin_inv;
        end
    end

endmodule : rodc_regs

`default_nettype wire

// ===== dv/rodc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module rodc_chk (
    input wire logic       clk_in,                        // Clock
    input wire logic       arst_n_in,                     // Reset, active low
    input wire logic       reg_wr_en_in,                  // Write strobe
    input wire logic       reg_rd_en_in,                  // Read strobe
    input wire logic [7:0] reg_addr_in,                   // Address
    input wire logic [7:0] reg_wdata_in,                  // Write data
    input wire logic       ext_ref_detect_in,             // Reference present
    input wire logic       output_standard_select_pin_in, // Strap
    input wire logic [7:0] reg_rdata_out,                 // Read data
    input wire logic       reg_rvalid_out,                // Read valid
    input wire logic [5:0] crystal_cap_qtr_pf_out,        // Tuning cap
    input wire logic       doubler_en_out,                // Doubler
    input wire logic       use_ext_ref_out,               // External reference
    input wire logic       use_crystal_input_out,         // Crystal input
    input wire logic       drv_strong_out,                // Strong drive
    input wire logic       drv_power_down_out,            // Power-down
    input wire logic [2:0] drv_mode_out,                  // Mode
    input wire logic       drv_cmos_out,                  // CMOS
    input wire logic [1:0] drv_pin_inv_out                // Inversion
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    wire logic w_tune = reg_wr_en_in && reg_addr_in == 8'h1b;
    wire logic w_ref  = reg_wr_en_in && reg_addr_in == 8'h1d;
    wire logic w_drv  = reg_wr_en_in && reg_addr_in == 8'h32;
    // Derived outputs land one edge after the write is taken, so they are first sampled two edges on
    tune_auto_a: assert property (w_tune && reg_wdata_in[7] |-> ##2 crystal_cap_qtr_pf_out == 6'h00)
        else $error("tuning cap not zero in auto");
    tune_code_a: assert property (w_tune && !reg_wdata_in[7] |-> ##2
        crystal_cap_qtr_pf_out == ~$past(reg_wdata_in[5:0], 2))
        else $error("tuning cap not inverted code");
    doubler_sel_a: assert property (w_ref |-> ##2 doubler_en_out == $past(reg_wdata_in[2], 2))
        else $error("doubler select wrong");
    ref_auto_a: assert property (w_ref && !reg_wdata_in[0] |-> ##2 use_ext_ref_out == $past(ext_ref_detect_in))
        else $error("automatic reference routing wrong");
    ref_force_a: assert property (w_ref && reg_wdata_in[0] |-> ##2 use_crystal_input_out && !use_ext_ref_out)
        else $error("crystal override ignored");
    drv_fields_a: assert property (w_drv && reg_wdata_in[0] |-> ##2
        {drv_strong_out, drv_mode_out} == $past({reg_wdata_in[7], reg_wdata_in[5:3]}, 2))
        else $error("driver fields wrong");
    pdown_sel_a: assert property (w_drv && reg_wdata_in[0] |-> ##2
        drv_power_down_out == $past(reg_wdata_in[6], 2))
        else $error("power-down select wrong");
    pin_sense_a: assert property (w_drv && reg_wdata_in[0] && !reg_wdata_in[5] |-> ##2
        drv_cmos_out && drv_pin_inv_out == {~$past(reg_wdata_in[1], 2), $past(reg_wdata_in[2], 2)})
        else $error("pin senses wrong");
    pol_ignore_a: assert property (w_drv && reg_wdata_in[0] && reg_wdata_in[5] |-> ##2
        !drv_cmos_out && drv_pin_inv_out == 2'b00)
        else $error("polarity active outside CMOS");
    strap_mode_a: assert property (w_drv && !reg_wdata_in[0] |-> ##2
        drv_strong_out && drv_mode_out == {2'b10, $past(output_standard_select_pin_in)})
        else $error("strap mode not followed");
    unused_read_a: assert property (reg_rd_en_in && reg_addr_in == 8'h1c |=>
        reg_rvalid_out && reg_rdata_out == 8'h00)
        else $error("reserved register not zero");
endmodule : rodc_chk
`default_nettype wire

// ===== dv/rodc_host.sv
`timescale 1ns/10ps
`default_nettype none
module rodc_host (
    input  wire logic  clk_in,    // Clock
    output logic       wr_out,    // Write strobe
    output logic       rd_out,    // Read strobe
    output logic [7:0] addr_out,  // Address
    output logic [7:0] wdata_out  // Write data
);
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr_out = w;
        rd_out = !w;
        addr_out = a;
        wdata_out = d;
        @(negedge clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        // Idle lines flip so a stale value never passes for a live one
        addr_out = ~a;
        wdata_out = ~d;
    endtask : xfer
    // Dirty writes keep unused bits set on purpose
    task automatic write(input logic [7:0] a, input logic [7:0] d, input logic dirty);
        logic [7:0] m;
        m = a == 8'h1b ? 8'hbf : a == 8'h1d ? 8'h05 : a == 8'h32 ? 8'hff : 8'h00;
        xfer(1'b1, a, dirty ? d : d & m);
    endtask : write
endmodule : rodc_host
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk_in = 1'b0;
    logic        arst_n_in = 1'b0;
    logic        det = 1'b0;
    logic        strap = 1'b0;
    logic        wr, rd, rvalid;
    logic [7:0]  addr, wdata, rdata;
    wire logic [21:0] seen;
    int          n_fail = 0;
    int          compares = 0;
    int          m1b, m1d, m32, k;
    localparam logic [7:0] ADDRS [6] = '{8'h1b, 8'h1c, 8'h1d, 8'h32, 8'h00, 8'hff};

    always #2 clk_in = ~clk_in;
    rodc_host u_host (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
    rodc_regs u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_wr_en_in(wr), .reg_rd_en_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .ext_ref_detect_in(det),
        .output_standard_select_pin_in(strap), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .crystal_cap_auto_out(seen[21]), .crystal_cap_qtr_pf_out(seen[20:15]), .doubler_en_out(seen[14]),
        .use_ext_ref_out(seen[13]), .use_crystal_input_out(seen[12]), .drv_strong_out(seen[11]),
        .drv_power_down_out(seen[10]), .drv_mode_out(seen[9:7]), .drv_cmos_out(seen[6]),
        .drv_lvds_out(seen[5]), .drv_lvpecl_out(seen[4]), .drv_pin_en_out(seen[3:2]),
        .drv_pin_inv_out(seen[1:0]));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [21:0] model();
        int en, md, pol, ce, ci;
        en  = m32 & 1;
        md  = en ? m32 >> 3 & 7 : 4 + strap;
        pol = m32 >> 1 & 3;
        ce  = md == 0 ? 3 : md == 1 ? 1 : md == 2 ? 2 : 0;
        ci  = md < 4 ? (pol & 1 ? 0 : 2) + (pol >> 1) : 0;
        return {1'(m1b >> 7), 6'(m1b >> 7 ? 0 : ~m1b & 63), 1'(m1d >> 2), 1'(!(m1d & 1) && det),
                1'((m1d & 1) || !det), 1'(en ? m32 >> 7 : 1), 1'(en ? m32 >> 6 & 1 : 0), 3'(md),
                1'(md < 4), 1'(md == 4), 1'(md == 5), 2'(ce), 2'(ci)};
    endfunction : model
    task automatic results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic chk(input logic [21:0] s, input logic [21:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic reset_dut(input int n);
        arst_n_in = 1'b0;
        m1b = 8'h80;
        m1d = 0;
        m32 = 8'ha8;
        repeat (n) @(negedge clk_in);
        arst_n_in = 1'b1;
        @(negedge clk_in);
        chk(seen, model());
    endtask : reset_dut
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic dirty);
        u_host.write(a, d, dirty);
        if (a == 8'h1b) m1b = d & 8'hbf;
        if (a == 8'h1d) m1d = d & 8'h05;
        if (a == 8'h32) m32 = d;
        @(negedge clk_in);
        chk(seen, model());
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        int i;
        u_host.xfer(1'b0, a, 8'h00);
        for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk_in);
        if (i == 4) begin
            n_fail++;
            results();
        end else begin
            chk({14'h0, rdata}, {14'h0, 8'(a == 8'h1b ? m1b : a == 8'h1d ? m1d : a == 8'h32 ? m32 : 0)});
        end
    endtask : rd_reg

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        k = $urandom(32'heab6);
        reset_dut(5);
        for (k = 0; k < 6; k++) rd_reg(ADDRS[k]);
        $display("test reset done");
        wr_reg(8'h1b, 8'h00, 1'b0);
        wr_reg(8'h1b, 8'h3f, 1'b0);
        repeat (4) wr_reg(8'h1b, 8'($urandom), 1'b0);
        $display("test tuning done");
        for (k = 0; k < 8; k++) begin
            det = k[0];
            wr_reg(8'h1d, 8'((k >> 1 & 1) | (k & 4)), 1'b0);
        end
        $display("test reference done");
        for (k = 0; k < 36; k++) begin
            strap = 1'($urandom);
            // Last four leave serial control off so the strap decides
            wr_reg(8'h32, 8'(($urandom & 8'hc0) | (k << 1) | (k < 32 ? 1 : 0)), 1'b0);
        end
        rd_reg(8'h32);
        $display("test driver done");
        wr_reg(8'h1b, 8'hff, 1'b1);
        wr_reg(8'h1d, 8'hff, 1'b1);
        wr_reg(8'h1c, 8'hff, 1'b1);
        wr_reg(8'h40, 8'h5a, 1'b1);
        for (k = 0; k < 6; k++) rd_reg(ADDRS[k]);
        reset_dut(2);
        $display("test unused and reset done");
        results();
    end
endmodule : tb
bind rodc_regs rodc_chk u_chk (.clk_in, .arst_n_in, .reg_wr_en_in, .reg_rd_en_in, .reg_addr_in,
    .reg_wdata_in, .ext_ref_detect_in, .output_standard_select_pin_in, .reg_rdata_out, .reg_rvalid_out,
    .crystal_cap_qtr_pf_out, .doubler_en_out, .use_ext_ref_out, .use_crystal_input_out, .drv_strong_out,
    .drv_power_down_out, .drv_mode_out, .drv_cmos_out, .drv_pin_inv_out);
`default_nettype wire
